// >>> hdl/pmt_top.sv
/*
  Eighteen port pins with direction and special-function muxing, plus two
  32-bit down-counting timers with interval and toggle modes.
  Assumes all pin inputs are synchronous to clk_sys; the interrupt
  controller and DMA engine sit outside and take the request levels.
  Assumes clk_en is high for normal running; low freezes every register.
*/
// Chosen here: the strobed register port.

// Summary of operation
// RULE1: two 32-bit timers, interval or toggle
// RULE2: interval time-out gives one-cycle output pulse
// RULE3: toggle time-out inverts output, raises request
// RULE4: request raised at every count-out
// RULE5: enable loads base value, then decrements
// RULE6: expiry reloads base, counting continues
// RULE7: halt keeps count, no reload
// RULE8: period is base value plus one
// RULE9: live count readable, writable, reset 0x0fffffff
// RULE10: software changes base only while disabled
// RULE11: eighteen pins: input, output or special
// RULE12: pins 0-7 direction from mode register only; code takes it from the direction register
// RULE13: pins 8-17 carry irq, dma, timer functions
// RULE14: special enable overrides direction register
// RULE15: filter passes level held three clocks
// RULE16: dma request 0 bits 22,21,20
// RULE17: dma request 1 bits 25,24,23
// RULE18: dma acknowledge 0 bits 27,26
// RULE19: dma acknowledge 1 bits 29,28
// RULE20: bits 30,31 route timers to pins
// RULE21: irq 1-3 fields at 9:5,14:10,19:15
// RULE22: data bits map to pins one-to-one
// RULE23: direction bit 1 output; per-timer enable, mode
// RULE24: irq field: enable, filter, polarity bits
module pmt_top (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire pmt_pkg::pmt_req_t reg_req,
  output logic [31:0] reg_rdata,
  // Port pins
  input wire logic [pmt_pkg::PMT_NPINS-1:0] pin_in,
  output pmt_pkg::pmt_pins_t pin_out,
  // DMA acknowledge from the DMA engine, active high
  input wire logic [1:0] dma_ack_in,
  // Requests to interrupt controller and DMA engine
  output pmt_pkg::pmt_events_t events
);
  import pmt_pkg::*;

  // Direction and control keep all 32 bits so software reads back what it
  // wrote; only the low 18 direction bits reach the pins
  // Software registers
  logic [31:0] direction_q;
  logic [31:0] control_q;
  logic [PMT_NPINS-1:0] pin_data_q;
  logic [31:0] tmode_q;
  logic [31:0] base_q [2];
  logic [31:0] count_q [2];
  // The run flag remembers last cycle's enable, so a fresh enable is seen
  // as a rising edge and loads the base value once, unless a count write takes priority in that cycle
  // Timer state
  logic [1:0] run_q;
  logic [1:0] tout_q;
  logic [1:0] tirq_q;
  // History clears to zero in reset, so a pin that idles high needs three
  // clocks before its filtered level follows it
  // Filter history and filtered levels for six special inputs
  logic [PMT_FILTER_TAPS-1:0] hist_q [6];
  logic [5:0] filt_q;
  // Read data register
  logic [31:0] rdata_q;

  // Strobes are one cycle long; a write lands at the edge that samples it
  // Register write decode helper
  function automatic logic wr_hit(input pmt_req_t r, input logic [15:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Field n starts at bit 5n: bit 4 enables, bit 3 filters, bit 0 polarity
  // Interrupt request field accessors, fields laid out from bit 0
  function automatic logic irq_bit(input logic [31:0] c, input int n, input int ofs);
    return c[n * PMT_IRQ_FIELD_W + ofs];
  endfunction

  // Slots 0 to 3 are the interrupt request pins, 4 and 5 the DMA request
  // pins; one slot layout lets filter and request logic loop over all six
  // Control decode per special input: enable, filter, polarity
  logic [5:0] sf_en;
  logic [5:0] sf_filt;
  logic [5:0] sf_pol;
  logic [5:0] sf_pin;
  always_comb begin
    for (int n = 0; n < PMT_NIRQ; n++) begin
      sf_en[n] = irq_bit(control_q, n, PMT_IRQ_EN_OFS); // see RULE21 see RULE24
      sf_filt[n] = irq_bit(control_q, n, PMT_IRQ_FILT_OFS);
      sf_pol[n] = irq_bit(control_q, n, PMT_IRQ_POL_OFS);
      sf_pin[n] = pin_in[PMT_PIN_IRQ0 + n];
    end
    sf_en[4] = control_q[PMT_DREQ0_EN]; // see RULE16
    sf_filt[4] = control_q[PMT_DREQ0_FILT];
    sf_pol[4] = control_q[PMT_DREQ0_POL];
    sf_pin[4] = pin_in[PMT_PIN_DREQ0];
    sf_en[5] = control_q[PMT_DREQ1_EN]; // see RULE17
    sf_filt[5] = control_q[PMT_DREQ1_FILT];
    sf_pol[5] = control_q[PMT_DREQ1_POL];
    sf_pin[5] = pin_in[PMT_PIN_DREQ1];
  end

  // A level that flips inside the window leaves the filtered value alone,
  // so short glitches never reach the request output of a slot with its filter bit set
  // Three-tap filter: pass a level only once it held three clocks
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int n = 0; n < 6; n++) begin
        hist_q[n] <= '0;
      end
      filt_q <= '0;
    end else if (clk_en) begin
      for (int n = 0; n < 6; n++) begin
        hist_q[n] <= {hist_q[n][PMT_FILTER_TAPS-2:0], sf_pin[n]};
        if (&hist_q[n]) begin
          filt_q[n] <= 1'b1; // see RULE15
        end else if (~|hist_q[n]) begin
          filt_q[n] <= 1'b0;
        end
      end
    end
  end

  // A disabled slot never raises a request, whatever its pin does
  // Special input requests, polarity applied, gated by enable
  logic [5:0] sf_req;
  always_comb begin
    for (int n = 0; n < 6; n++) begin
      // Polarity 1 means active high
      sf_req[n] = sf_en[n] && ((sf_filt[n] ? filt_q[n] : sf_pin[n]) == sf_pol[n]);
    end
  end

  // Writes to unmapped addresses fall through every decode and change
  // nothing, which keeps stray software writes harmless
  // Register writes: port registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      direction_q <= PMT_RST_WORD;
      control_q <= PMT_RST_WORD;
      pin_data_q <= '0;
    end else if (clk_en) begin
      if (wr_hit(reg_req, PMT_ADDR_DIRECTION)) begin
        direction_q <= reg_req.wdata; // see RULE23
      end
      if (wr_hit(reg_req, PMT_ADDR_SF_CONTROL)) begin
        control_q <= reg_req.wdata;
      end
      if (wr_hit(reg_req, PMT_ADDR_PIN_DATA)) begin
        pin_data_q <= reg_req.wdata[PMT_NPINS-1:0]; // see RULE22
      end
    end
  end

  // A base write to a running timer only shows at its next reload; the
  // counter itself is never disturbed by it
  // Register writes: timer mode and base values
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tmode_q <= PMT_RST_WORD;
      base_q[0] <= PMT_RST_WORD;
      base_q[1] <= PMT_RST_WORD;
    end else if (clk_en) begin
      if (wr_hit(reg_req, PMT_ADDR_TIMER_MODE)) begin
        tmode_q <= reg_req.wdata;
      end
      // Written any time; software keeps it for disabled timers, see RULE10
      if (wr_hit(reg_req, PMT_ADDR_T0_BASE)) begin
        base_q[0] <= reg_req.wdata;
      end
      if (wr_hit(reg_req, PMT_ADDR_T1_BASE)) begin
        base_q[1] <= reg_req.wdata;
      end
    end
  end

  // Each timer owns a three-bit slot in the mode word; the top bit is spare
  // Per-timer enable and mode
  logic [1:0] t_en;
  pmt_mode_t t_mode [2];
  logic [1:0] t_cnt_wr;
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      t_en[t] = tmode_q[PMT_TMR_EN0 + t * PMT_TMR_STRIDE]; // see RULE23
      t_mode[t] = pmt_mode_t'(tmode_q[PMT_TMR_MODE0 + t * PMT_TMR_STRIDE]);
    end
    t_cnt_wr[0] = wr_hit(reg_req, PMT_ADDR_T0_COUNT);
    t_cnt_wr[1] = wr_hit(reg_req, PMT_ADDR_T1_COUNT);
  end

  // Priority per timer: software count write, then load on a fresh enable,
  // then counting. A base of zero times out every cycle, so an interval
  // output then stays high.
  // Timer counters: load on enable, decrement, reload on time-out
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_q[0] <= PMT_RST_COUNT; // see RULE9
      count_q[1] <= PMT_RST_COUNT;
      run_q <= '0;
      tout_q <= '0;
      tirq_q <= '0;
    end else if (clk_en) begin
      for (int t = 0; t < 2; t++) begin
        // Remember the enable to catch its rising edge
        run_q[t] <= t_en[t];
        // Request pulse lasts one clock unless set again below
        tirq_q[t] <= 1'b0;
        if (t_cnt_wr[t]) begin
          count_q[t] <= reg_req.wdata; // see RULE9
        end else if (t_en[t] && !run_q[t]) begin
          count_q[t] <= base_q[t]; // see RULE5
          if (t_mode[t] == PMT_MODE_INTERVAL) begin
            tout_q[t] <= 1'b0;
          end
        end else if (t_en[t]) begin
          if (count_q[t] == '0) begin
            // Count-out: base+1 cycles after load, see RULE8
            count_q[t] <= base_q[t]; // see RULE6
            tirq_q[t] <= 1'b1; // see RULE4
            if (t_mode[t] == PMT_MODE_TOGGLE) begin
              tout_q[t] <= ~tout_q[t]; // see RULE3
            end else begin
              tout_q[t] <= 1'b1; // see RULE2
            end
          end else begin
            count_q[t] <= count_q[t] - PMT_ONE; // see RULE1
            if (t_mode[t] == PMT_MODE_INTERVAL) begin
              tout_q[t] <= 1'b0;
            end
          end
        end else if (t_mode[t] == PMT_MODE_INTERVAL) begin
          // Halted: count held, no reload, see RULE7
          tout_q[t] <= 1'b0;
        end
      end
    end
  end

  // Later assignments win, so special functions override the direction
  // bits; input functions release the pin so an outside device can drive it
  // Pin drive: direction register, overridden by special functions
  logic [PMT_NPINS-1:0] oe_c;
  logic [PMT_NPINS-1:0] dout_c;
  always_comb begin
    oe_c = direction_q[PMT_NPINS-1:0]; // see RULE11 see RULE12
    dout_c = pin_data_q;
    for (int n = 0; n < PMT_NIRQ; n++) begin
      if (sf_en[n]) begin
        oe_c[PMT_PIN_IRQ0 + n] = 1'b0; // see RULE14
      end
    end
    if (sf_en[4]) begin
      oe_c[PMT_PIN_DREQ0] = 1'b0;
    end
    if (sf_en[5]) begin
      oe_c[PMT_PIN_DREQ1] = 1'b0;
    end
    if (control_q[PMT_DACK0_EN]) begin
      // Polarity 1 drives ack high when active, see RULE18
      oe_c[PMT_PIN_DACK0] = 1'b1;
      dout_c[PMT_PIN_DACK0] = ~(dma_ack_in[0] ^ control_q[PMT_DACK0_POL]);
    end
    if (control_q[PMT_DACK1_EN]) begin
      oe_c[PMT_PIN_DACK1] = 1'b1; // see RULE19
      dout_c[PMT_PIN_DACK1] = ~(dma_ack_in[1] ^ control_q[PMT_DACK1_POL]);
    end
    if (control_q[PMT_TIMER0_OUTPUT_EN]) begin
      oe_c[PMT_PIN_TIMER0_OUTPUT] = 1'b1; // see RULE20 see RULE13
      dout_c[PMT_PIN_TIMER0_OUTPUT] = tout_q[0];
    end
    if (control_q[PMT_TIMER1_OUTPUT_EN]) begin
      oe_c[PMT_PIN_TIMER1_OUTPUT] = 1'b1;
      dout_c[PMT_PIN_TIMER1_OUTPUT] = tout_q[1];
    end
  end

  // Registered drive keeps the pins glitch-free, at the cost of one clock
  // after any register or timer change
  // Pin outputs registered
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_out <= '0;
      events <= '0;
    end else if (clk_en) begin
      pin_out.oe <= oe_c;
      pin_out.dout <= dout_c;
      events.ext_irq <= sf_req[PMT_NIRQ-1:0];
      events.dma_req <= sf_req[5:4];
      events.timer_irq <= tirq_q;
    end
  end

  // Output pins read back what the block drives, not what the pin settles at
  // Pin data read: inputs show pin level, outputs show driven value
  logic [PMT_NPINS-1:0] pin_rd;
  always_comb begin
    for (int n = 0; n < PMT_NPINS; n++) begin
      pin_rd[n] = oe_c[n] ? dout_c[n] : pin_in[n]; // see RULE22
    end
  end

  // Read data stands for one cycle after the strobe and then returns to
  // zero, so a stale value never lingers on the bus
  // Read decode; unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= PMT_RST_WORD;
    end else if (clk_en) begin
      if (!reg_req.rd) begin
        rdata_q <= PMT_RST_WORD;
      end else if (reg_req.addr == PMT_ADDR_DIRECTION) begin
        rdata_q <= direction_q;
      end else if (reg_req.addr == PMT_ADDR_SF_CONTROL) begin
        rdata_q <= control_q;
      end else if (reg_req.addr == PMT_ADDR_PIN_DATA) begin
        rdata_q <= {{(32-PMT_NPINS){1'b0}}, pin_rd};
      end else if (reg_req.addr == PMT_ADDR_TIMER_MODE) begin
        rdata_q <= tmode_q;
      end else if (reg_req.addr == PMT_ADDR_T0_BASE) begin
        rdata_q <= base_q[0];
      end else if (reg_req.addr == PMT_ADDR_T1_BASE) begin
        rdata_q <= base_q[1];
      end else if (reg_req.addr == PMT_ADDR_T0_COUNT) begin
        rdata_q <= count_q[0]; // see RULE9
      end else if (reg_req.addr == PMT_ADDR_T1_COUNT) begin
        rdata_q <= count_q[1];
      end else begin
        rdata_q <= PMT_RST_WORD;
      end
    end
  end

  // Read data leaves straight from its flip-flop
  assign reg_rdata = rdata_q;

endmodule

// >>> hdl/pmt_pkg.sv
/*
  Package for the port mux and interval timer block: register offsets,
  control field positions, reset values, mode encodings and carrier structs.
  Assumes a single 250 MHz system clock and a plain strobe register port.
*/
package pmt_pkg;

  // Register byte addresses
  localparam logic [15:0] PMT_ADDR_DIRECTION = 16'h5000;
  localparam logic [15:0] PMT_ADDR_SF_CONTROL = 16'h5004;
  localparam logic [15:0] PMT_ADDR_PIN_DATA = 16'h5008;
  localparam logic [15:0] PMT_ADDR_TIMER_MODE = 16'h6000;
  localparam logic [15:0] PMT_ADDR_T0_BASE = 16'h6004;
  localparam logic [15:0] PMT_ADDR_T1_BASE = 16'h6008;
  localparam logic [15:0] PMT_ADDR_T0_COUNT = 16'h600c;
  localparam logic [15:0] PMT_ADDR_T1_COUNT = 16'h6010;

  // Widths
  localparam int PMT_NPINS = 18;
  localparam int PMT_NIRQ = 4;

  // Reset values
  localparam logic [31:0] PMT_RST_WORD = 32'h0000_0000;
  localparam logic [31:0] PMT_RST_COUNT = 32'h0fff_ffff;
  localparam logic [31:0] PMT_ONE = 32'h0000_0001;

  // Pin positions of the special functions
  localparam int PMT_PIN_IRQ0 = 8;
  localparam int PMT_PIN_DREQ0 = 12;
  localparam int PMT_PIN_DREQ1 = 13;
  localparam int PMT_PIN_DACK0 = 14;
  localparam int PMT_PIN_DACK1 = 15;
  localparam int PMT_PIN_TIMER0_OUTPUT = 16;
  localparam int PMT_PIN_TIMER1_OUTPUT = 17;

  // Control word fields: interrupt request fields are 5 bits each from bit 0
  localparam int PMT_IRQ_FIELD_W = 5;
  localparam int PMT_IRQ_EN_OFS = 4;
  localparam int PMT_IRQ_FILT_OFS = 3;
  localparam int PMT_IRQ_POL_OFS = 0;
  localparam int PMT_DREQ0_EN = 22;
  localparam int PMT_DREQ0_FILT = 21;
  localparam int PMT_DREQ0_POL = 20;
  localparam int PMT_DREQ1_EN = 25;
  localparam int PMT_DREQ1_FILT = 24;
  localparam int PMT_DREQ1_POL = 23;
  localparam int PMT_DACK0_EN = 27;
  localparam int PMT_DACK0_POL = 26;
  localparam int PMT_DACK1_EN = 29;
  localparam int PMT_DACK1_POL = 28;
  localparam int PMT_TIMER0_OUTPUT_EN = 30;
  localparam int PMT_TIMER1_OUTPUT_EN = 31;

  // Timer mode word: per timer an enable and a mode bit
  localparam int PMT_TMR_EN0 = 0;
  localparam int PMT_TMR_MODE0 = 1;
  localparam int PMT_TMR_STRIDE = 3;

  // Filter length in system clocks
  localparam int PMT_FILTER_TAPS = 3;

  // Timer mode encoding
  typedef enum logic {
    PMT_MODE_INTERVAL = 1'b0,
    PMT_MODE_TOGGLE = 1'b1
  } pmt_mode_t;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pmt_req_t;

  // Two-way pin group
  typedef struct packed {
    logic [PMT_NPINS-1:0] dout;
    logic [PMT_NPINS-1:0] oe;
  } pmt_pins_t;

  // Requests passed to interrupt controller and DMA engine
  typedef struct packed {
    logic [PMT_NIRQ-1:0] ext_irq;
    logic [1:0] dma_req;
    logic [1:0] timer_irq;
  } pmt_events_t;

endpackage

// >>> dv/pmt_checker.sv
/*
  Port-level checker for pmt_top: pins, requests, timer pulses and reads.
  Assumes clk_en stays high and that control writes come over reg_req.
*/
module pmt_checker (
  // Clock, reset, run enable
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire pmt_pkg::pmt_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  // Pins, acknowledges, requests
  input wire logic [pmt_pkg::PMT_NPINS-1:0] pin_in,
  input wire pmt_pkg::pmt_pins_t pin_out,
  input wire logic [1:0] dma_ack_in,
  input wire pmt_pkg::pmt_events_t events
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmt_pkg::*;
  logic [31:0] dir_q, con_q, mode_q, base0_q; // Shadows of written registers
  logic [31:0] gap_q; // Clocks since the last timer 0 pulse
  logic seen_q; // A timer 0 pulse was seen since enable
  // Shadow register writes as the block takes them
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_q <= '0;
      con_q <= '0;
      mode_q <= '0;
      base0_q <= '0;
    end else if (clk_en && reg_req.wr) begin
      case (reg_req.addr)
        PMT_ADDR_DIRECTION: dir_q <= reg_req.wdata;
        PMT_ADDR_SF_CONTROL: con_q <= reg_req.wdata;
        PMT_ADDR_TIMER_MODE: mode_q <= reg_req.wdata;
        PMT_ADDR_T0_BASE: base0_q <= reg_req.wdata;
        default: ;
      endcase
    end
  end
  // Measure spacing of timer 0 pulses while it runs
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !mode_q[0]) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= events.timer_irq[0] ? 32'h0000_0001 : gap_q + 32'h0000_0001;
      seen_q <= seen_q | events.timer_irq[0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Filtered active-high request held steady
  sequence dreq0_held;
    (con_q[22:20] == 3'b111 && pin_in[12])[*8];
  endsequence
  chk_low_pins_dir: assert property (
    pin_out.oe[7:0] == $past(dir_q[7:0])) else $error("low pin enable mismatch");
  chk_dack0_drive: assert property ($past(con_q[27]) |-> pin_out.oe[14] &&
    pin_out.dout[14] == ($past(dma_ack_in[0]) ~^ $past(con_q[26]))) else $error("ack0 pin");
  chk_dack1_drive: assert property ($past(con_q[29]) |-> pin_out.oe[15] &&
    pin_out.dout[15] == ($past(dma_ack_in[1]) ~^ $past(con_q[28]))) else $error("ack1 pin");
  chk_timer0_output_pulse: assert property ($past(con_q[30]) && !$past(mode_q[1]) |->
    pin_out.oe[16] && pin_out.dout[16] == events.timer_irq[0]) else $error("timer0 pin");
  chk_timer1_output_toggle: assert property (
    $past(con_q[31], 2) && $past(con_q[31]) && $past(mode_q[4], 2) |->
    (pin_out.dout[17] != $past(pin_out.dout[17])) == events.timer_irq[1])
    else $error("timer1 toggle");
  chk_t0_period: assert property (
    events.timer_irq[0] && seen_q |-> gap_q == base0_q + PMT_ONE) else $error("timer0 period");
  chk_dreq0_filter: assert property (
    dreq0_held |-> events.dma_req[0]) else $error("filtered request not passed");
  chk_pin_upper: assert property (
    $past(reg_req.rd) && $past(reg_req.addr) == PMT_ADDR_PIN_DATA |-> reg_rdata[31:18] == '0)
    else $error("pin data upper bits set");
endmodule

bind pmt_top pmt_checker i_pmt_checker (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
  .dma_ack_in(dma_ack_in), .events(events));

// >>> dv/pmt_pin_model.sv
/*
  Outside devices on the port pins: they present levels where the block does not drive.
  Assumes the bench chooses the offered levels at clock edges.
*/
module pmt_pin_model (
  // Levels offered by outside devices
  input wire logic [17:0] ext_lvl,
  // Block pin drive
  input wire pmt_pkg::pmt_pins_t pin_out,
  // Resolved pin levels fed back to the block
  output logic [17:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmt_pkg::*;
  // A driven pin shows the block's level, an undriven one the outside level
  assign pin_in = (pin_out.oe & pin_out.dout) | (~pin_out.oe & ext_lvl);
endmodule

// >>> dv/port_mux_with_interval_timers_tb.sv
/*
  Bench for pmt_top: reset values, pins, special functions and both timers.
  Assumes the pin model closes the pin loop; clk_en is held high.
*/
module port_mux_with_interval_timers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmt_pkg::*;
  logic clk_sys = 1'b0; // 250 MHz clock
  logic sys_rst = 1'b1; // Reset, held two cycles
  logic clk_en = 1'b1; // Always running
  pmt_req_t req = '0; // Register request
  logic [31:0] reg_rdata, d1, d2; // Read data and captures
  logic [17:0] pin_in, ext_lvl = '0; // Pin levels
  pmt_pins_t pin_out;
  logic [1:0] dma_ack_in = '0; // Acknowledges from the DMA side
  pmt_events_t events;
  int n_errors = 0;
  int n_checks = 0;
  // Clock
  always #2 clk_sys = ~clk_sys;
  pmt_top i_pmt_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .reg_req(req),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .dma_ack_in(dma_ack_in),
    .events(events));
  pmt_pin_model i_pmt_pin_model (.ext_lvl(ext_lvl), .pin_out(pin_out), .pin_in(pin_in));
  // Compare and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle write
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Wait for the next timer request pulse, counting clocks
  task automatic wait_tirq(input int t, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (events.timer_irq[t] !== 1'b1 && n < 100);
  endtask
  // Reset values, then an unmapped read
  task automatic t_reset;
    logic [15:0] a[7] = '{PMT_ADDR_DIRECTION, PMT_ADDR_SF_CONTROL, PMT_ADDR_TIMER_MODE,
      PMT_ADDR_T0_BASE, PMT_ADDR_T1_BASE, PMT_ADDR_T0_COUNT, PMT_ADDR_T1_COUNT};
    for (int i = 0; i < 7; i++) begin
      rd(a[i], d1);
      chk("reset value", (i > 4) ? PMT_RST_COUNT : PMT_RST_WORD, d1);
    end
    rd(16'h7000, d1);
    chk("unmapped read", 32'h0000_0000, d1);
  endtask
  // Plain pins in both directions
  task automatic t_pins;
    ext_lvl <= 18'h2_5a3c;
    wr(PMT_ADDR_DIRECTION, 32'h0000_00f0);
    wr(PMT_ADDR_PIN_DATA, 32'h0000_0055);
    // Pin drive follows the data register one clock later
    @(posedge clk_sys);
    #1 chk("pin enables", 32'h0000_00f0, {14'h0, pin_out.oe});
    chk("pin drive", 32'h0000_0005, {28'h0, pin_out.dout[7:4]});
    rd(PMT_ADDR_PIN_DATA, d1);
    chk("pin data", {14'h0, (18'h2_5a3c & ~18'h0_00f0) | 18'h0_0050}, d1);
  endtask
  // Acknowledge outputs override the direction bits
  task automatic t_dack;
    wr(PMT_ADDR_SF_CONTROL, 32'h2c00_0000);
    dma_ack_in <= 2'b01;
    repeat (3) @(posedge clk_sys);
    #1 chk("ack pins", 32'h0000_000f, {28'h0, pin_out.oe[15:14], pin_out.dout[15:14]});
    dma_ack_in <= 2'b10;
    repeat (3) @(posedge clk_sys);
    #1 chk("ack pins", 32'h0000_000c, {28'h0, pin_out.oe[15:14], pin_out.dout[15:14]});
  endtask
  // Filtered request ignores a glitch; unfiltered low-active request
  task automatic t_dreq;
    ext_lvl <= 18'h0_2000;
    // Let the request 0 filter settle low before the glitch
    repeat (4) @(posedge clk_sys);
    wr(PMT_ADDR_SF_CONTROL, 32'h0270_0000);
    ext_lvl[12] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    ext_lvl[12] <= 1'b0;
    d1 = '0;
    repeat (8) begin
      @(posedge clk_sys);
      #1 d1 = d1 | {30'h0, events.dma_req};
    end
    chk("glitch blocked", 32'h0000_0000, d1);
    ext_lvl[13:12] <= 2'b01;
    repeat (10) @(posedge clk_sys);
    #1 chk("requests", 32'h0000_0003, {30'h0, events.dma_req});
  endtask
  // Each interrupt request field on its own pin
  task automatic t_irq;
    ext_lvl <= '0;
    for (int n = 0; n < 4; n++) begin
      wr(PMT_ADDR_SF_CONTROL, 32'h0000_0011 << (5 * n));
      ext_lvl[8 + n] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 chk("ext irq", 32'h0000_0001 << n, {28'h0, events.ext_irq});
      ext_lvl[8 + n] <= 1'b0;
    end
    // Filtered active-low request 0: asserted while low, drops after three clocks high
    wr(PMT_ADDR_SF_CONTROL, 32'h0000_0018);
    repeat (2) @(posedge clk_sys);
    #1 chk("low irq", 32'h0000_0001, {28'h0, events.ext_irq});
    ext_lvl[8] <= 1'b1;
    repeat (7) @(posedge clk_sys);
    #1 chk("low irq off", 32'h0000_0000, {28'h0, events.ext_irq});
  endtask
  // Both timers: load, period, reload, toggle, halt
  task automatic t_timer;
    int n;
    logic l1;
    wr(PMT_ADDR_T0_COUNT, 32'h0000_1234);
    rd(PMT_ADDR_T0_COUNT, d1);
    chk("count write", 32'h0000_1234, d1);
    wr(PMT_ADDR_T0_BASE, 32'h0000_0003);
    wr(PMT_ADDR_T1_BASE, 32'h0000_0002);
    wr(PMT_ADDR_SF_CONTROL, 32'hc000_0000);
    wr(PMT_ADDR_TIMER_MODE, 32'h0000_0019);
    wait_tirq(0, n);
    chk("first time-out", 32'd6, 32'(n));
    wait_tirq(0, n);
    chk("timer0 period", 32'd4, 32'(n));
    chk("timer0 pin", 32'h0000_0001, {31'h0, pin_out.dout[16]});
    wait_tirq(1, n);
    l1 = pin_out.dout[17];
    wait_tirq(1, n);
    chk("timer1 period", 32'd3, 32'(n));
    chk("timer1 toggle", {31'h0, ~l1}, {31'h0, pin_out.dout[17]});
    wr(PMT_ADDR_TIMER_MODE, 32'h0000_0000);
    rd(PMT_ADDR_T0_COUNT, d1);
    repeat (6) @(posedge clk_sys);
    rd(PMT_ADDR_T0_COUNT, d2);
    chk("halted count", d1, d2);
  endtask
  // Verdict and end of run
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #20000;
    n_errors++;
    give_verdict;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset;
    t_pins;
    t_dack;
    t_dreq;
    t_irq;
    t_timer;
    give_verdict;
  end
endmodule
